// file: shared/sdoc_pkg.sv
// How it works
// - word bit 15 enables its whole bank
// - disabled bank outputs sit at code zero
// - disabled bank clears its eight data registers
// - sequencer restarts on re-enable, then rewrites every channel
// - low twelve bits are unsigned code 0..4095
// - code zero bottom, 4095 full scale, linear
// - controller converts bcd values to binary
// - select bits binary: zero first, seven eighth
// - at most one channel per bank per scan
// - bank enables act independently of each other
// - sequencer sends same select in both words
// - sequencer starts and restarts at first channels
// - data writes never disturb enable; manual words also carry select
// - select in bits 12..14, lower word channels 1..8
// - link carries two 16-bit words, 16 channels
`default_nettype none
package sdoc_pkg;

    localparam int WORD_W = 16;
    localparam int DATA_W = 12;
    localparam int SEL_LSB = 12;
    localparam int SEL_W = 3;
    localparam int EN_BIT = 15;
    localparam int BANKS = 2;
    localparam int CH_PER_BANK = 8;
    localparam int CHANNELS = 16;

    typedef logic [DATA_W-1:0] sdoc_code_t;
    typedef logic [WORD_W-1:0] sdoc_word_t;
    typedef logic [SEL_W-1:0] sdoc_sel_t;

    localparam sdoc_code_t CODE_ZERO = 12'h000;
    localparam sdoc_code_t CODE_FULL = 12'hfff;
    localparam sdoc_word_t WORD_RESET = 16'h0000;

    // controller register map, byte addresses on apb
    localparam int ADDR_W = 12;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_MAN_LO = 12'h008;
    localparam logic [11:0] REG_MAN_HI = 12'h00c;
    localparam logic [5:0] TABLE_PAGE = 6'h01;
    localparam int TABLE_IDX_LSB = 2;
    localparam int TABLE_PAGE_LSB = 6;

    localparam int CTRL_AUTO = 0;
    localparam int CTRL_EN_LO = 1;
    localparam int CTRL_EN_HI = 2;
    localparam int CTRL_BCD = 3;
    localparam int CTRL_SEND = 4;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam int STAT_PEND = 4;
    localparam int STAT_EN_LSB = 8;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    localparam int CLK_PERIOD_NS = 40;
    localparam int SCAN_TIME_NS = 10000;
    localparam int SCAN_CYCLES = SCAN_TIME_NS / CLK_PERIOD_NS;

    function automatic sdoc_code_t word_code(input sdoc_word_t w);
        return w[DATA_W-1:0];
    endfunction

    function automatic sdoc_sel_t word_sel(input sdoc_word_t w);
        return w[SEL_LSB+SEL_W-1:SEL_LSB];
    endfunction

    function automatic sdoc_word_t make_word(input logic en,
                                             input sdoc_sel_t sel,
                                             input sdoc_code_t code);
        return {en, sel, code};
    endfunction

    // three bcd digits, 0..999; invalid digits are not trapped
    function automatic sdoc_code_t bcd_to_bin(input sdoc_code_t b);
        int v;
        v = 100 * int'(b[11:8]) + 10 * int'(b[7:4]) + int'(b[3:0]);
        return sdoc_code_t'(v);
    endfunction

endpackage
`default_nettype wire

// file: shared/sdoc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sdoc_link_if;
    logic [15:0] word_lo;
    logic [15:0] word_hi;
    logic word_strobe;
    modport dac_end (
        input word_lo,
        input word_hi,
        input word_strobe
    );
    modport ctrl_end (
        output word_lo,
        output word_hi,
        output word_strobe
    );
endinterface
`default_nettype wire

// file: verilog/sdoc_dac_end.sv
`timescale 1ns/10ps
`default_nettype none
module sdoc_dac_end (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // link from the controller
    sdoc_link_if.dac_end link,
    // converter side
    output logic [sdoc_pkg::CHANNELS-1:0][sdoc_pkg::DATA_W-1:0] chan_code,
    output logic [sdoc_pkg::BANKS-1:0] bank_on,
    output logic [sdoc_pkg::CHANNELS-1:0] chan_write
);
    import sdoc_pkg::*;

    // the two link words as last written
    sdoc_word_t points_reg [BANKS];
    sdoc_code_t code_reg [CHANNELS];
    logic [CHANNELS-1:0] write_reg;
    sdoc_word_t word_in [BANKS];
    logic [BANKS-1:0] word_en;
    logic [BANKS-1:0] held_en;

    assign word_in[0] = link.word_lo;
    assign word_in[1] = link.word_hi;

    genvar b, c;
    generate
        for (b = 0; b < BANKS; b++) begin : g_bank
            // each bank looks only at its own word
            assign word_en[b] = word_in[b][EN_BIT];
            assign held_en[b] = points_reg[b][EN_BIT];
            assign bank_on[b] = points_reg[b][EN_BIT];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    points_reg[b] <= WORD_RESET;
                end else if (ce && link.word_strobe) begin
                    points_reg[b] <= word_in[b];
                end
            end

            for (c = 0; c < CH_PER_BANK; c++) begin : g_chan
                localparam int N = b * CH_PER_BANK + c;
                wire hit;
                wire kill;
                // select code c picks the (c+1)th channel of the bank
                assign hit = link.word_strobe && word_en[b] &&
                             word_sel(word_in[b]) == sdoc_sel_t'(c);
                // a disabling word, or a bank held off, zeroes the code
                assign kill = link.word_strobe ? !word_en[b]
                                               : !held_en[b];
                assign chan_code[N] = code_reg[N];

                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        code_reg[N] <= CODE_ZERO;
                        write_reg[N] <= 1'b0;
                    end else if (ce) begin
                        write_reg[N] <= hit;
                        if (kill) begin
                            code_reg[N] <= CODE_ZERO;
                        end else if (hit) begin
                            // full 12-bit range, no clamping needed
                            code_reg[N] <= word_code(word_in[b]);
                        end
                    end
                end
                // other channels keep their code
            end
        end
    endgenerate

    assign chan_write = write_reg;

endmodule
`default_nettype wire

// file: verilog/sdoc_ctrl_end.sv
`timescale 1ns/10ps
`default_nettype none
module sdoc_ctrl_end #(
    parameter int SCAN_CYC = sdoc_pkg::SCAN_CYCLES
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sdoc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link to the converter
    sdoc_link_if.ctrl_end link
);
    import sdoc_pkg::*;

    logic [CTRL_W-1:0] ctrl_reg;
    logic [14:0] man_lo_reg;
    logic [14:0] man_hi_reg;
    sdoc_code_t table_mem [CHANNELS];
    logic pend_reg;
    sdoc_sel_t idx_reg;
    logic [15:0] timer_reg;
    sdoc_word_t lo_reg;
    sdoc_word_t hi_reg;
    logic strobe_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    wire setup = psel && !penable;
    wire wr = psel && penable && pwrite;
    wire hit_ctrl = paddr == REG_CTRL;
    wire hit_stat = paddr == REG_STATUS;
    wire hit_mlo = paddr == REG_MAN_LO;
    wire hit_mhi = paddr == REG_MAN_HI;
    wire hit_tab = paddr[ADDR_W-1:TABLE_PAGE_LSB] == TABLE_PAGE &&
                   paddr[1:0] == 2'h0;
    wire [3:0] tab_idx = paddr[TABLE_PAGE_LSB-1:TABLE_IDX_LSB];
    wire mapped = hit_ctrl || hit_stat || hit_mlo || hit_mhi || hit_tab;

    wire en_lo = ctrl_reg[CTRL_EN_LO];
    wire en_hi = ctrl_reg[CTRL_EN_HI];
    wire auto_on = ctrl_reg[CTRL_AUTO];
    wire bcd_on = ctrl_reg[CTRL_BCD];
    wire wr_ctrl = wr && hit_ctrl;
    // re-enabling a bank restarts the pass so every channel is rewritten
    wire en_rise = wr_ctrl &&
                   ((pwdata[CTRL_EN_LO] && !en_lo) ||
                    (pwdata[CTRL_EN_HI] && !en_hi));
    wire restart = !auto_on || en_rise;
    wire tick = timer_reg == 16'h0000;
    wire issue = tick && (auto_on || pend_reg);
    wire set_pend = wr_ctrl && pwdata[CTRL_SEND];

    wire [31:0] rd_mux =
        hit_ctrl ? {28'h0, ctrl_reg} :
        hit_stat ? {22'h0, en_hi, en_lo, 3'h0, pend_reg, 1'b0, idx_reg} :
        hit_mlo ? {17'h0, man_lo_reg} :
        hit_mhi ? {17'h0, man_hi_reg} :
        hit_tab ? {20'h0, table_mem[tab_idx]} : RD_ZERO;

    // table or manual data, optionally bcd, reduced to the twelve data bits
    sdoc_code_t raw_lo;
    sdoc_code_t raw_hi;
    sdoc_code_t code_lo;
    sdoc_code_t code_hi;
    sdoc_sel_t sel_lo;
    sdoc_sel_t sel_hi;
    assign raw_lo = auto_on ? table_mem[{1'b0, idx_reg}]
                            : man_lo_reg[DATA_W-1:0];
    assign raw_hi = auto_on ? table_mem[{1'b1, idx_reg}]
                            : man_hi_reg[DATA_W-1:0];
    assign code_lo = bcd_on ? bcd_to_bin(raw_lo) : raw_lo;
    assign code_hi = bcd_on ? bcd_to_bin(raw_hi) : raw_hi;
    // same index in both words during a sequenced pass
    assign sel_lo = auto_on ? idx_reg : man_lo_reg[14:12];
    assign sel_hi = auto_on ? idx_reg : man_hi_reg[14:12];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
            man_lo_reg <= 15'h0000;
            man_hi_reg <= 15'h0000;
        end else if (ce && wr) begin
            if (hit_ctrl) ctrl_reg <= pwdata[CTRL_W-1:0];
            if (hit_mlo) man_lo_reg <= pwdata[14:0];
            if (hit_mhi) man_hi_reg <= pwdata[14:0];
        end
    end

    // no reset: table contents are software data
    always_ff @(posedge pclk) begin
        if (ce && wr && hit_tab) begin
            table_mem[tab_idx] <= pwdata[DATA_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= RD_ZERO;
            pslverr_reg <= 1'b0;
            pready_reg <= 1'b0;
        end else if (ce) begin
            pready_reg <= 1'b1;
            if (setup) begin
                prdata_reg <= rd_mux;
                pslverr_reg <= !mapped;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_reg <= 16'h0000;
            pend_reg <= 1'b0;
            idx_reg <= 3'h0;
        end else if (ce) begin
            timer_reg <= tick ? 16'(SCAN_CYC - 1) : timer_reg - 16'h0001;
            // a new send request wins over the one being issued
            pend_reg <= set_pend || (pend_reg && !(issue && !auto_on));
            if (restart) begin
                idx_reg <= 3'h0;
            end else if (issue) begin
                idx_reg <= idx_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_reg <= WORD_RESET;
            hi_reg <= WORD_RESET;
            strobe_reg <= 1'b0;
        end else if (ce) begin
            strobe_reg <= issue;
            if (issue) begin
                // enable comes from control, never from data; select from idx_reg or the manual word
                lo_reg <= make_word(en_lo, sel_lo, code_lo);
                hi_reg <= make_word(en_hi, sel_hi, code_hi);
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign link.word_lo = lo_reg;
    assign link.word_hi = hi_reg;
    assign link.word_strobe = strobe_reg;

endmodule
`default_nettype wire

// file: bench/sdoc_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ce is held high by the bench, so every strobe is taken
module sdoc_link_sva (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link words
    input wire logic [15:0] word_lo,
    input wire logic [15:0] word_hi,
    input wire logic word_strobe,
    // converter side
    input wire logic [15:0][11:0] chan_code,
    input wire logic [1:0] bank_on,
    input wire logic [15:0] chan_write
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_en_lo;
        word_strobe |=> bank_on[0] == $past(word_lo[15]);
    endproperty
    a_en_lo: assert property (p_en_lo)
        else $error("lower enable not taken");
    property p_en_hi;
        word_strobe |=> bank_on[1] == $past(word_hi[15]);
    endproperty
    a_en_hi: assert property (p_en_hi)
        else $error("upper enable not taken");
    property p_off_zero;
        !bank_on[0] |-> chan_code[7:0] == '0;
    endproperty
    a_off_zero: assert property (p_off_zero)
        else $error("disabled lower bank not at zero");
    property p_clear_hi;
        word_strobe && !word_hi[15] |=>
            chan_code[15:8] == '0 && chan_write[15:8] == 8'h00;
    endproperty
    a_clear_hi: assert property (p_clear_hi)
        else $error("upper bank not cleared");
    property p_sel_lo;
        word_strobe && word_lo[15] |=>
            chan_write[7:0] == 8'h01 << $past(word_lo[14:12]);
    endproperty
    a_sel_lo: assert property (p_sel_lo)
        else $error("wrong lower channel written");
    property p_code_hi;
        word_strobe && word_hi[15] |=>
            chan_code[8 + $past(word_hi[14:12])] == $past(word_hi[11:0]);
    endproperty
    a_code_hi: assert property (p_code_hi)
        else $error("upper code not latched");
    property p_hold;
        !word_strobe |=> $stable(chan_code) && chan_write == 16'h0000;
    endproperty
    a_hold: assert property (p_hold)
        else $error("channel code moved without strobe");
    property p_two;
        $countones(chan_write) <= 2;
    endproperty
    a_two: assert property (p_two)
        else $error("more than two channels written");
    c_full: cover property (word_strobe && word_lo[11:0] == 12'hfff);
    c_split: cover property (bank_on == 2'b10);
    c_last: cover property (word_strobe && word_hi[14:12] == 3'h7);
endmodule
`default_nettype wire

// file: bench/sixteen_channel_dac_output_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sixteen_channel_dac_output_control_bench;
    import sdoc_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic ce = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0][11:0] chan_code;
    logic [1:0] bank_on;
    logic [15:0] chan_write;
    logic [11:0] exp_code [16] = '{default: 12'h000};
    logic [31:0] rd;
    logic er;
    int failures = 0;
    int cmp_count = 0;
    always #20 pclk = ~pclk;
    sdoc_link_if link ();
    sdoc_ctrl_end #(.SCAN_CYC(4)) i_sdoc_ctrl_end (.pclk(pclk),
        .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link.ctrl_end));
    sdoc_dac_end i_sdoc_dac_end (.pclk(pclk), .presetn(presetn), .ce(ce),
        .link(link.dac_end), .chan_code(chan_code), .bank_on(bank_on),
        .chan_write(chan_write));
    sdoc_link_sva i_sdoc_link_sva (.pclk(pclk), .presetn(presetn),
        .word_lo(link.word_lo), .word_hi(link.word_hi),
        .word_strobe(link.word_strobe), .chan_code(chan_code),
        .bank_on(bank_on), .chan_write(chan_write));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_codes(input string nm);
        for (int i = 0; i < 16; i++) begin
            chk(nm, {20'h0, exp_code[i]}, {20'h0, chan_code[i]});
        end
    endtask
    // holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic xfer();
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (chan_write === 16'h0000 && n < 60);
        chk("transfer", 32'h1, {31'h0, |chan_write});
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        chk("bank reset", 32'h0, {30'h0, bank_on});
        $display("test registers done");
        apb(1'b1, REG_CTRL, 32'h6);
        for (int s = 0; s < 8; s++) begin
            exp_code[s] = 12'hfff - 12'(s * 585);
            exp_code[8 + s] = 12'(s * 585);
            apb(1'b1, REG_MAN_LO, {17'h0, s[2:0], exp_code[s]});
            apb(1'b1, REG_MAN_HI, {17'h0, s[2:0], exp_code[8 + s]});
            apb(1'b1, REG_CTRL, 32'h16);
            xfer();
        end
        chk_codes("manual codes");
        $display("test selects done");
        // data word with bit 15 set must not turn the lower bank on
        apb(1'b1, REG_MAN_LO, 32'h0000_ffff);
        apb(1'b1, REG_CTRL, 32'h14);
        xfer();
        for (int i = 0; i < 8; i++) exp_code[i] = 12'h000;
        chk_codes("lower disabled");
        chk("bank split", 32'h2, {30'h0, bank_on});
        apb(1'b1, REG_MAN_LO, 32'h0000_2abc);
        apb(1'b1, REG_CTRL, 32'h16);
        xfer();
        exp_code[2] = 12'habc;
        chk_codes("re-enabled");
        $display("test disable done");
        for (int n = 0; n < 16; n++) begin
            exp_code[n] = 12'(n * 273);
            apb(1'b1, 12'(12'h040 + 4 * n), {20'h0, exp_code[n]});
        end
        apb(1'b1, REG_CTRL, 32'h7);
        repeat (8) xfer();
        apb(1'b1, REG_CTRL, 32'h6);
        chk_codes("auto codes");
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status", 32'h300, rd);
        $display("test sequence done");
        // bcd 999 on lower channel 4, bcd 123 on upper channel 14
        apb(1'b1, REG_MAN_LO, 32'h0000_3999);
        apb(1'b1, REG_MAN_HI, 32'h0000_5123);
        apb(1'b1, REG_CTRL, 32'h1e);
        xfer();
        exp_code[3] = 12'h3e7;
        exp_code[13] = 12'h07b;
        chk_codes("bcd codes");
        $display("test bcd done");
        report_and_stop();
    end
endmodule
`default_nettype wire
